// ### logic/csb_exec.sv
// compare, skip and branch execution unit
`timescale 1ns/10ps
module csb_exec #(
  parameter int unsigned PC_W = 16
) (
  input wire logic clk, // core clock
  input wire logic rst, // synchronous reset
  input wire logic ce, // clock enable
  input wire logic req_valid, // instruction present
  input wire csb_pkg::csb_req_t req, // decoded instruction
  output logic [15:0] pc_o, // program counter
  output logic [7:0] status_o, // status register
  output logic [1:0] cycles_o, // cycles of last instruction
  output logic done_o // one-cycle completion pulse
);

  csb_pkg::csb_state_t s_q;
  csb_pkg::csb_state_t s_d;

  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] cmp_flags(input logic [7:0] d, input logic [7:0] r,
                                           input logic cin, input logic [7:0] old,
                                           input logic zkeep);
    logic [8:0] diff;
    logic [7:0] f;
    diff = {1'b0, d} - {1'b0, r} - {8'h00, cin};
    f = old;
    f[csb_pkg::FLAG_C] = diff[8];
    f[csb_pkg::FLAG_N] = diff[7];
    f[csb_pkg::FLAG_V] = (d[7] & ~r[7] & ~diff[7]) | (~d[7] & r[7] & diff[7]);
    f[csb_pkg::FLAG_S] = diff[7] ^ f[csb_pkg::FLAG_V];
    f[csb_pkg::FLAG_H] = (~d[3] & r[3]) | (r[3] & diff[3]) | (diff[3] & ~d[3]);
    // with carry, zero only stays set if it was already set
    f[csb_pkg::FLAG_Z] = (diff[7:0] == 8'h00) & (zkeep ? old[csb_pkg::FLAG_Z] : 1'b1);
    return f;
  endfunction

  ////////////////////////////////////////////////////////////////
  logic take;
  logic is_skip;
  logic is_branch;
  logic [15:0] k_ext;

  always_comb begin
    s_d = s_q;
    take = 1'b0;
    is_skip = 1'b0;
    is_branch = 1'b0;
    k_ext = {{9{req.disp[6]}}, req.disp};
    s_d.done = 1'b0;
    if (req_valid) begin
      s_d.done = 1'b1;
      case (req.op)
        csb_pkg::OP_COMPARE_WITH_CARRY: begin
          s_d.status = cmp_flags(req.dst, req.src, s_q.status[csb_pkg::FLAG_C],
                                 s_q.status, 1'b1);
        end
        csb_pkg::OP_COMPARE_IMMEDIATE: begin
          s_d.status = cmp_flags(req.dst, req.src, 1'b0, s_q.status, 1'b0);
        end
        csb_pkg::OP_SKIP_REG_BIT_CLEAR: begin
          is_skip = 1'b1;
          take = ~req.src[req.bit_sel];
        end
        csb_pkg::OP_SKIP_REG_BIT_SET: begin
          is_skip = 1'b1;
          take = req.src[req.bit_sel];
        end
        csb_pkg::OP_SKIP_IO_BIT_CLEAR: begin
          is_skip = 1'b1;
          take = ~req.io_val[req.bit_sel];
        end
        csb_pkg::OP_SKIP_IO_BIT_SET: begin
          is_skip = 1'b1;
          take = req.io_val[req.bit_sel];
        end
        csb_pkg::OP_BRANCH_STATUS_BIT_SET: begin
          is_branch = 1'b1;
          take = s_q.status[req.bit_sel];
        end
        csb_pkg::OP_BRANCH_STATUS_BIT_CLEAR: begin
          is_branch = 1'b1;
          take = ~s_q.status[req.bit_sel];
        end
        csb_pkg::OP_BRANCH_EQUAL: begin
          is_branch = 1'b1;
          take = s_q.status[csb_pkg::FLAG_Z];
        end
        csb_pkg::OP_BRANCH_NOT_EQUAL: begin
          is_branch = 1'b1;
          take = ~s_q.status[csb_pkg::FLAG_Z];
        end
        csb_pkg::OP_BRANCH_CARRY_SET, csb_pkg::OP_BRANCH_LOWER: begin
          is_branch = 1'b1;
          take = s_q.status[csb_pkg::FLAG_C];
        end
        csb_pkg::OP_BRANCH_CARRY_CLEAR, csb_pkg::OP_BRANCH_SAME_OR_HIGHER: begin
          is_branch = 1'b1;
          take = ~s_q.status[csb_pkg::FLAG_C];
        end
        default: begin
          s_d.done = 1'b0;
        end
      endcase
      s_d.cycles = csb_pkg::CYC_ONE;
      s_d.pc = s_q.pc + csb_pkg::PC_STEP;
      if (is_skip && take) begin
        // skipping a two-word instruction costs one extra cycle
        s_d.pc = s_q.pc + (req.next_two_word ? csb_pkg::SKIP_TWO_WORD
                                             : csb_pkg::SKIP_ONE_WORD);
        s_d.cycles = req.next_two_word ? csb_pkg::CYC_THREE : csb_pkg::CYC_TWO;
      end
      if (is_branch && take) begin
        s_d.pc = s_q.pc + k_ext + csb_pkg::PC_STEP;
        s_d.cycles = csb_pkg::CYC_TWO;
      end
      if (!s_d.done) begin
        s_d.pc = s_q.pc;
        s_d.cycles = s_q.cycles;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q.pc <= csb_pkg::PC_RESET;
      s_q.status <= csb_pkg::STATUS_RESET;
      s_q.cycles <= 2'h0;
      s_q.done <= 1'b0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign pc_o = s_q.pc;
  assign status_o = s_q.status;
  assign cycles_o = s_q.cycles;
  assign done_o = s_q.done;

  ////////////////////////////////////////////////////////////////
  a_imm_zero_flag: assert property (@(posedge clk) disable iff (rst)
    (ce && req_valid && req.op == csb_pkg::OP_COMPARE_IMMEDIATE && req.dst == req.src)
    |=> status_o[csb_pkg::FLAG_Z] && !status_o[csb_pkg::FLAG_C] && cycles_o == 2'h1)
    else $error("compare immediate of equal values gave wrong flags");

  a_skip_reg_pc: assert property (@(posedge clk) disable iff (rst)
    (ce && req_valid && req.op == csb_pkg::OP_SKIP_REG_BIT_SET && req.src[req.bit_sel])
    |=> pc_o == $past(pc_o) + (($past(req.next_two_word)) ? 16'h0003 : 16'h0002))
    else $error("register bit skip moved pc wrongly");

  a_skip_io_flags: assert property (@(posedge clk) disable iff (rst)
    (ce && req_valid && (req.op == csb_pkg::OP_SKIP_IO_BIT_CLEAR ||
     req.op == csb_pkg::OP_SKIP_IO_BIT_SET)) |=> $stable(status_o))
    else $error("io bit skip changed flags");

  a_status_set_target: assert property (@(posedge clk) disable iff (rst)
    (ce && req_valid && req.op == csb_pkg::OP_BRANCH_STATUS_BIT_SET &&
     status_o[req.bit_sel]) |=> pc_o == $past(pc_o) + {{9{$past(req.disp[6])}},
     $past(req.disp)} + 16'h0001 && cycles_o == 2'h2 && $stable(status_o))
    else $error("status bit branch target wrong");

  a_bne_not_taken: assert property (@(posedge clk) disable iff (rst)
    (ce && req_valid && req.op == csb_pkg::OP_BRANCH_NOT_EQUAL &&
     status_o[csb_pkg::FLAG_Z]) |=> pc_o == $past(pc_o) + 16'h0001 && cycles_o == 2'h1)
    else $error("branch not equal taken with zero set");

  a_carry_set_cycles: assert property (@(posedge clk) disable iff (rst)
    (ce && req_valid && req.op == csb_pkg::OP_BRANCH_CARRY_SET &&
     !status_o[csb_pkg::FLAG_C]) |=> cycles_o == 2'h1 && done_o)
    else $error("carry set branch cost wrong");

  a_same_higher_taken: assert property (@(posedge clk) disable iff (rst)
    (ce && req_valid && req.op == csb_pkg::OP_BRANCH_SAME_OR_HIGHER &&
     !status_o[csb_pkg::FLAG_C]) |=> cycles_o == 2'h2)
    else $error("same or higher branch not taken");

  a_back_branch: assert property (@(posedge clk) disable iff (rst)
    (ce && req_valid && req.op == csb_pkg::OP_BRANCH_EQUAL && req.disp == 7'h7e &&
     status_o[csb_pkg::FLAG_Z]) |=> pc_o == $past(pc_o) - 16'h0001)
    else $error("negative displacement not applied");

  a_skip_clear_pc: assert property (@(posedge clk) disable iff (rst)
    (ce && req_valid && req.op == csb_pkg::OP_SKIP_REG_BIT_CLEAR && !req.src[req.bit_sel] &&
     !req.next_two_word) |=> pc_o == $past(pc_o) + 16'h0002 && cycles_o == 2'h2)
    else $error("register bit clear skip moved pc wrongly");

  a_io_skip_cost: assert property (@(posedge clk) disable iff (rst)
    (ce && req_valid && req.op == csb_pkg::OP_SKIP_IO_BIT_SET && req.io_val[req.bit_sel] &&
     req.next_two_word) |=> pc_o == $past(pc_o) + 16'h0003 && cycles_o == 2'h3)
    else $error("io bit skip over two words cost wrong");

  a_chain_zero_keep: assert property (@(posedge clk) disable iff (rst)
    (ce && req_valid && req.op == csb_pkg::OP_COMPARE_WITH_CARRY &&
     !status_o[csb_pkg::FLAG_Z]) |=> !status_o[csb_pkg::FLAG_Z] && cycles_o == 2'h1)
    else $error("compare with carry set zero anew");

  a_status_clear_idle: assert property (@(posedge clk) disable iff (rst)
    (ce && req_valid && req.op == csb_pkg::OP_BRANCH_STATUS_BIT_CLEAR &&
     status_o[req.bit_sel]) |=> pc_o == $past(pc_o) + 16'h0001 && cycles_o == 2'h1)
    else $error("status bit clear branch taken with bit set");

  a_equal_flags_kept: assert property (@(posedge clk) disable iff (rst)
    (ce && req_valid && req.op == csb_pkg::OP_BRANCH_EQUAL &&
     status_o[csb_pkg::FLAG_Z]) |=> cycles_o == 2'h2 && $stable(status_o))
    else $error("branch equal not taken or flags changed");

  a_carry_clear_idle: assert property (@(posedge clk) disable iff (rst)
    (ce && req_valid && req.op == csb_pkg::OP_BRANCH_CARRY_CLEAR &&
     status_o[csb_pkg::FLAG_C]) |=> pc_o == $past(pc_o) + 16'h0001 && cycles_o == 2'h1)
    else $error("carry clear branch taken with carry set");

  a_lower_taken: assert property (@(posedge clk) disable iff (rst)
    (ce && req_valid && req.op == csb_pkg::OP_BRANCH_LOWER &&
     status_o[csb_pkg::FLAG_C]) |=> cycles_o == 2'h2 && done_o)
    else $error("lower branch not taken with carry set");

endmodule

// ### common/csb_pkg.sv
// package for the compare, skip and branch execution block
package csb_pkg;
  // status register bit positions
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_H = 5;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;
  // program counter advances
  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam logic [15:0] SKIP_ONE_WORD = 16'h0002;
  localparam logic [15:0] SKIP_TWO_WORD = 16'h0003;
  // cycle counts
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_COMPARE_WITH_CARRY,
    OP_COMPARE_IMMEDIATE,
    OP_SKIP_REG_BIT_CLEAR,
    OP_SKIP_REG_BIT_SET,
    OP_SKIP_IO_BIT_CLEAR,
    OP_SKIP_IO_BIT_SET,
    OP_BRANCH_STATUS_BIT_SET,
    OP_BRANCH_STATUS_BIT_CLEAR,
    OP_BRANCH_EQUAL,
    OP_BRANCH_NOT_EQUAL,
    OP_BRANCH_CARRY_SET,
    OP_BRANCH_CARRY_CLEAR,
    OP_BRANCH_SAME_OR_HIGHER,
    OP_BRANCH_LOWER
  } csb_op_t;

  // one decoded instruction as handed over by the core
  typedef struct packed {
    csb_op_t op;
    logic [7:0] dst;
    logic [7:0] src;
    logic [7:0] io_val;
    logic [2:0] bit_sel;
    logic [6:0] disp;
    logic next_two_word;
  } csb_req_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] status;
    logic [1:0] cycles;
    logic done;
  } csb_state_t;
endpackage

// ### sim/csb_exec_test.sv
// self-checking testbench for the compare, skip and branch unit
`timescale 1ns/10ps
module csb_exec_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic req_valid = 1'b0;
  csb_pkg::csb_req_t req = '0;
  logic [15:0] pc_o;
  logic [7:0] status_o;
  logic [1:0] cycles_o;
  logic done_o;
  logic [15:0] pc_m = 16'h0000;
  logic [7:0] st_m = 8'h00;
  logic [1:0] cy_m = 2'h0;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  csb_exec csb_exec_i (.clk(clk), .rst(rst), .ce(ce), .req_valid(req_valid), .req(req),
    .pc_o(pc_o), .status_o(status_o), .cycles_o(cycles_o), .done_o(done_o));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("err_total %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic cmp(logic [15:0] got, logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one instruction through the unit, checked against a model of the documented effect
  task automatic run(csb_pkg::csb_op_t op, logic [7:0] d, logic [7:0] s, logic [7:0] io,
      logic [2:0] b, logic [6:0] k, logic two);
    logic [8:0] r;
    logic [4:0] h;
    logic c;
    logic tk;
    logic live;
    c = (op == csb_pkg::OP_COMPARE_WITH_CARRY) ? st_m[0] : 1'b0;
    live = ce && op != csb_pkg::OP_NONE;
    case (op)
      csb_pkg::OP_SKIP_REG_BIT_CLEAR: tk = !s[b];
      csb_pkg::OP_SKIP_REG_BIT_SET: tk = s[b];
      csb_pkg::OP_SKIP_IO_BIT_CLEAR: tk = !io[b];
      csb_pkg::OP_SKIP_IO_BIT_SET: tk = io[b];
      csb_pkg::OP_BRANCH_STATUS_BIT_SET: tk = st_m[b];
      csb_pkg::OP_BRANCH_STATUS_BIT_CLEAR: tk = !st_m[b];
      csb_pkg::OP_BRANCH_EQUAL: tk = st_m[1];
      csb_pkg::OP_BRANCH_NOT_EQUAL: tk = !st_m[1];
      csb_pkg::OP_BRANCH_CARRY_SET, csb_pkg::OP_BRANCH_LOWER: tk = st_m[0];
      default: tk = !st_m[0];
    endcase
    if (live && op <= csb_pkg::OP_COMPARE_IMMEDIATE) begin
      r = {1'b0, d} - {1'b0, s} - c;
      h = {1'b0, d[3:0]} - s[3:0] - c;
      st_m[0] = r[8];
      // chained compare: zero may only stay set, never be set anew
      st_m[1] = (r[7:0] == 8'h00) && (op == csb_pkg::OP_COMPARE_WITH_CARRY ? st_m[1] : 1'b1);
      st_m[2] = r[7];
      st_m[3] = (d[7] & ~s[7] & ~r[7]) | (~d[7] & s[7] & r[7]);
      st_m[4] = st_m[2] ^ st_m[3];
      st_m[5] = h[4];
      tk = 1'b0;
    end
    if (live) begin
      cy_m = !tk ? 2'h1 : (op <= csb_pkg::OP_SKIP_IO_BIT_SET) ? (two ? 2'h3 : 2'h2) : 2'h2;
      pc_m = pc_m + (!tk ? 16'h0001 : (op <= csb_pkg::OP_SKIP_IO_BIT_SET) ?
        {15'h0000, two} + 16'h0002 : {{9{k[6]}}, k} + 16'h0001);
    end
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{op, d, s, io, b, k, two};
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
    cmp(pc_o, pc_m);
    cmp({8'h00, status_o}, {8'h00, st_m});
    cmp({14'h0000, cycles_o}, {14'h0000, cy_m});
    cmp({15'h0000, done_o}, {15'h0000, live});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_compare();
    run(csb_pkg::OP_COMPARE_IMMEDIATE, 8'h05, 8'h05, 8'h00, 3'h0, 7'h00, 1'b0);
    run(csb_pkg::OP_COMPARE_IMMEDIATE, 8'h10, 8'h20, 8'h00, 3'h0, 7'h00, 1'b0);
    run(csb_pkg::OP_COMPARE_WITH_CARRY, 8'h80, 8'h00, 8'h00, 3'h0, 7'h00, 1'b0);
    run(csb_pkg::OP_COMPARE_IMMEDIATE, 8'h01, 8'h01, 8'h00, 3'h0, 7'h00, 1'b0);
    run(csb_pkg::OP_COMPARE_WITH_CARRY, 8'h00, 8'h00, 8'h00, 3'h0, 7'h00, 1'b0);
    run(csb_pkg::OP_COMPARE_IMMEDIATE, 8'h01, 8'h02, 8'h00, 3'h0, 7'h00, 1'b0);
    run(csb_pkg::OP_COMPARE_WITH_CARRY, 8'h01, 8'h00, 8'h00, 3'h0, 7'h00, 1'b0);
  endtask
  // every branch kind, taken and not taken, each kind in one direction only, alternately backward and forward
  task automatic t_branch(logic [7:0] a);
    run(csb_pkg::OP_COMPARE_IMMEDIATE, a, 8'h05, 8'h00, 3'h0, 7'h00, 1'b0);
    for (int i = 7; i < 15; i++) begin
      run(csb_pkg::csb_op_t'(i), 8'h00, 8'h00, 8'h00, 3'(i - 7), i[0] ? 7'h7e : 7'h03, 1'b0);
    end
  endtask
  task automatic t_skip();
    for (int i = 0; i < 8; i++) begin
      run(csb_pkg::csb_op_t'(3 + i % 4), 8'h00, 8'h5a, 8'h5a, 3'(i), 7'h00, i[0] ^ i[2]);
    end
  endtask
  task automatic t_refuse();
    run(csb_pkg::OP_NONE, 8'h00, 8'h00, 8'h00, 3'h0, 7'h00, 1'b0);
    @(posedge clk);
    ce <= 1'b0;
    // let the enable settle so the model sees it low
    #1;
    run(csb_pkg::OP_BRANCH_NOT_EQUAL, 8'h00, 8'h00, 8'h00, 3'h0, 7'h05, 1'b0);
    @(posedge clk);
    ce <= 1'b1;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    cmp(pc_o, 16'h0000);
    cmp({15'h0000, done_o}, 16'h0000);
    cmp({8'h00, status_o}, 16'h0000);
    cmp({14'h0000, cycles_o}, 16'h0000);
    t_compare();
    t_branch(8'h05);
    t_branch(8'h01);
    t_skip();
    t_refuse();
    end_sim();
  end
endmodule
